// File: hw/calendar_clock_alarm_chrono.sv
// calendar clock with alarm, timebase ticks and stopwatch behind a byte register port
`timescale 1ns/100ps

// Behaviour
// - keep time and calendar counters, month/leap aware
// - reads live, writes load and continue counting
// - alarm flag on hour and minute match
// - crystal select sets dividers to 1 Hz
// - second/minute/hour increments set their flags whether enabled or not
// - day increment sets day flag
// - years 1901 to 2099 with correct leaps
// - 2 Hz and 4 Hz timebase flags
// - stopwatch runs when enabled, wraps after 99
// - 128 Hz stopwatch on the 32.768 kHz chain converted to hundredths
// - runs in wait, requests wake processor
// - oscillator kept in stop keeps block running
// - stop without oscillator halts, keeps registers
// - interrupt enable register at 0x42, reset zero
// - stopwatch clear zeroes counter, reads zero
// - stopwatch counts hundredths, holds when disabled
// - module enable gates all counting, keeps registers
// - flags clear by status then data read
// - crystal select written once, fixed encodings
// - seconds/minutes wrap 59, hours 23, check writes
// - day wraps per month, invalid writes ignored
module calendar_clock_alarm_chrono #(
    parameter int QDIV_32K768 = rtc_pkg::REF_HZ_32K768 / rtc_pkg::TB_RATE_HZ,
    parameter int QDIV_32K000 = rtc_pkg::REF_HZ_32K000 / rtc_pkg::TB_RATE_HZ,
    parameter int QDIV_38K400 = rtc_pkg::REF_HZ_38K400 / rtc_pkg::TB_RATE_HZ,
    parameter int QDIV_64K000 = rtc_pkg::REF_HZ_64K000 / rtc_pkg::TB_RATE_HZ,
    parameter int QDIV_76K800 = rtc_pkg::REF_HZ_76K800 / rtc_pkg::TB_RATE_HZ
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic crystal_ref_clock,
    input wire logic stop_mode,
    input wire logic osc_run_in_stop,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic irq_req
);

    localparam int CDIV_32K768 = rtc_pkg::REF_HZ_32K768 / rtc_pkg::CHRONO_RATE_32K_HZ;
    localparam int CDIV_32K000 = rtc_pkg::REF_HZ_32K000 / rtc_pkg::CHRONO_RATE_HZ;
    localparam int CDIV_38K400 = rtc_pkg::REF_HZ_38K400 / rtc_pkg::CHRONO_RATE_HZ;
    localparam int CDIV_64K000 = rtc_pkg::REF_HZ_64K000 / rtc_pkg::CHRONO_RATE_HZ;
    localparam int CDIV_76K800 = rtc_pkg::REF_HZ_76K800 / rtc_pkg::CHRONO_RATE_HZ;

    initial
    begin
        if (QDIV_32K768 < 1 || QDIV_32K000 < 1 || QDIV_38K400 < 1 ||
            QDIV_64K000 < 1 || QDIV_76K800 < 1 || QDIV_32K768 > 65535 ||
            QDIV_32K000 > 65535 || QDIV_38K400 > 65535 || QDIV_64K000 > 65535 ||
            QDIV_76K800 > 65535)
        begin
            $error("quarter second divider out of range");
        end
    end

    logic [7:0] irq_en_q;
    logic chrono_en_q;
    logic module_en_q;
    logic [2:0] xtal_q;
    logic xtal_locked_q;
    rtc_pkg::flags_t flags_q;
    rtc_pkg::flags_t flags_d;
    logic [7:0] armed_q;
    logic [7:0] alm_min_q;
    logic [7:0] alm_hr_q;
    logic [7:0] sec_q;
    logic [7:0] min_q;
    logic [7:0] hr_q;
    logic [7:0] day_q;
    logic [7:0] mth_q;
    logic [7:0] yr_q;
    logic [7:0] dow_q;
    logic [6:0] chr_sub_q;
    logic [15:0] qpre_q;
    logic [1:0] tb_q;
    logic [15:0] cpre_q;
    logic ref_prev_q;
    logic match_q;
    logic [7:0] rdata_q;
    logic irq_q;

    logic ref_edge;
    logic run;
    logic [15:0] qdiv_last;
    logic [15:0] cdiv_last;
    logic is_32k;
    logic tick4;
    logic tick2;
    logic tick1;
    logic ctick;
    logic sec_wrap;
    logic min_wrap;
    logic hr_wrap;
    logic day_wrap;
    logic mth_wrap;
    logic [7:0] dim;
    logic match_now;
    logic [6:0] chr_sub_max;
    logic [13:0] chr_prod;
    logic [6:0] chr_val;
    logic [7:0] clr_mask;
    logic wr_sec;
    logic wr_min;
    logic wr_hr;
    logic wr_day;
    logic wr_mth;
    logic wr_yr;
    logic wr_dow;
    logic wr_ctl;
    logic chr_clr;

    assign ref_edge = crystal_ref_clock & ~ref_prev_q;
    // stop without oscillator freezes counting but leaves every register alone
    assign run = module_en_q & ~(stop_mode & ~osc_run_in_stop);

    assign wr_sec = wr_en && addr == rtc_pkg::OFS_SEC;
    assign wr_min = wr_en && addr == rtc_pkg::OFS_MIN;
    assign wr_hr = wr_en && addr == rtc_pkg::OFS_HR;
    assign wr_day = wr_en && addr == rtc_pkg::OFS_DAY;
    assign wr_mth = wr_en && addr == rtc_pkg::OFS_MTH;
    assign wr_yr = wr_en && addr == rtc_pkg::OFS_YR;
    assign wr_dow = wr_en && addr == rtc_pkg::OFS_DOW;
    assign wr_ctl = wr_en && addr == rtc_pkg::OFS_CTRL2;
    assign chr_clr = wr_ctl & wdata[rtc_pkg::CTL_CHR_CLR];

    // reserved code falls back to the 32.768 kHz chain
    always_comb
    begin
        is_32k = 1'b0;
        qdiv_last = 16'(QDIV_32K768 - 1);
        cdiv_last = 16'(CDIV_32K768 - 1);
        case (xtal_q)
            rtc_pkg::XTAL_32K768, rtc_pkg::XTAL_RSVD:
            begin
                is_32k = 1'b1;
            end
            rtc_pkg::XTAL_32K000:
            begin
                qdiv_last = 16'(QDIV_32K000 - 1);
                cdiv_last = 16'(CDIV_32K000 - 1);
            end
            rtc_pkg::XTAL_38K400:
            begin
                qdiv_last = 16'(QDIV_38K400 - 1);
                cdiv_last = 16'(CDIV_38K400 - 1);
            end
            default:
            begin
                qdiv_last = xtal_q[0] ? 16'(QDIV_76K800 - 1) : 16'(QDIV_64K000 - 1);
                cdiv_last = xtal_q[0] ? 16'(CDIV_76K800 - 1) : 16'(CDIV_64K000 - 1);
            end
        endcase
    end

    assign tick4 = run & ref_edge & (qpre_q == qdiv_last);
    assign tick2 = tick4 & tb_q[0];
    assign tick1 = tick4 & (tb_q == 2'h3);

    // year holds calendar year minus 1900, so leap is simply a multiple of four
    always_comb
    begin
        dim = rtc_pkg::DAYS_31;
        case (mth_q)
            8'h02: dim = (yr_q[1:0] == 2'h0) ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h0B: dim = rtc_pkg::DAYS_30;
            default: dim = rtc_pkg::DAYS_31;
        endcase
    end

    assign sec_wrap = tick1 & (sec_q == rtc_pkg::SEC_MAX);
    assign min_wrap = sec_wrap & (min_q == rtc_pkg::SEC_MAX);
    assign hr_wrap = min_wrap & (hr_q == rtc_pkg::HR_MAX);
    assign day_wrap = hr_wrap & (day_q >= dim);
    assign mth_wrap = day_wrap & (mth_q >= rtc_pkg::MTH_MAX);

    assign match_now = (min_q == alm_min_q) && (hr_q == alm_hr_q);

    assign chr_sub_max = is_32k ? rtc_pkg::CHR_SUB_MAX_32K : rtc_pkg::CHR_MAX;
    assign ctick = run & chrono_en_q & ref_edge & (cpre_q == cdiv_last);
    assign chr_prod = 14'(chr_sub_q) * 14'h0064;
    assign chr_val = is_32k ? chr_prod[13:7] : chr_sub_q;

    // data register read completes the clear only for flags seen set in the status read
    always_comb
    begin
        clr_mask = 8'h00;
        if (rd_en)
        begin
            case (addr)
                rtc_pkg::OFS_ALM_HR: clr_mask = 8'h80;
                rtc_pkg::OFS_CHR: clr_mask = 8'h43;
                rtc_pkg::OFS_DAY: clr_mask = 8'h20;
                rtc_pkg::OFS_HR: clr_mask = 8'h10;
                rtc_pkg::OFS_MIN: clr_mask = 8'h08;
                rtc_pkg::OFS_SEC: clr_mask = 8'h04;
                default: clr_mask = 8'h00;
            endcase
        end
        clr_mask = clr_mask & armed_q;
    end

    always_comb
    begin
        flags_d = flags_q & ~clr_mask;
        flags_d.second = flags_d.second | tick1;
        flags_d.minute = flags_d.minute | sec_wrap;
        flags_d.hour = flags_d.hour | min_wrap;
        flags_d.day = flags_d.day | hr_wrap;
        flags_d.half = flags_d.half | tick2;
        flags_d.quarter = flags_d.quarter | tick4;
        flags_d.chrono = flags_d.chrono | ctick;
        flags_d.alarm = flags_d.alarm | (match_now & ~match_q & run);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            flags_q <= '0;
            armed_q <= 8'h00;
            match_q <= 1'b0;
        end
        else if (clk_en)
        begin
            flags_q <= flags_d;
            match_q <= match_now;
            if (rd_en && addr == rtc_pkg::OFS_STATUS)
            begin
                armed_q <= flags_q;
            end
            else
            begin
                armed_q <= armed_q & ~clr_mask;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_en_q <= rtc_pkg::IRQ_EN_RST;
            chrono_en_q <= 1'b0;
            module_en_q <= 1'b0;
            xtal_q <= rtc_pkg::XTAL_RST;
            xtal_locked_q <= 1'b0;
            alm_min_q <= rtc_pkg::ZERO_RST;
            alm_hr_q <= rtc_pkg::ZERO_RST;
        end
        else if (clk_en && wr_en)
        begin
            if (addr == rtc_pkg::OFS_IRQ_EN)
            begin
                irq_en_q <= wdata;
            end
            if (wr_ctl)
            begin
                chrono_en_q <= wdata[rtc_pkg::CTL_CHR_EN];
                module_en_q <= wdata[rtc_pkg::CTL_MOD_EN];
                xtal_locked_q <= 1'b1;
                if (!xtal_locked_q)
                begin
                    xtal_q <= wdata[rtc_pkg::CTL_XTAL_MSB:0];
                end
            end
            if (addr == rtc_pkg::OFS_ALM_MIN)
            begin
                alm_min_q <= {2'b00, wdata[5:0]};
            end
            if (addr == rtc_pkg::OFS_ALM_HR)
            begin
                alm_hr_q <= {3'b000, wdata[4:0]};
            end
        end
    end

    // dividers off the sampled reference
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ref_prev_q <= 1'b0;
            qpre_q <= 16'h0000;
            tb_q <= 2'h0;
            cpre_q <= 16'h0000;
            chr_sub_q <= 7'h00;
        end
        else if (clk_en)
        begin
            ref_prev_q <= crystal_ref_clock;
            if (run && ref_edge)
            begin
                qpre_q <= (qpre_q >= qdiv_last) ? 16'h0000 : qpre_q + 16'h0001;
            end
            if (tick4)
            begin
                tb_q <= tb_q + 2'h1;
            end
            if (chr_clr)
            begin
                cpre_q <= 16'h0000;
                chr_sub_q <= 7'h00;
            end
            else if (run && chrono_en_q && ref_edge)
            begin
                cpre_q <= (cpre_q >= cdiv_last) ? 16'h0000 : cpre_q + 16'h0001;
                if (ctick)
                begin
                    chr_sub_q <= (chr_sub_q >= chr_sub_max) ? 7'h00 : chr_sub_q + 7'h01;
                end
            end
        end
    end

    // time counters; a valid write takes the place of the tick in that cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sec_q <= rtc_pkg::ZERO_RST;
            min_q <= rtc_pkg::ZERO_RST;
            hr_q <= rtc_pkg::ZERO_RST;
        end
        else if (clk_en)
        begin
            if (wr_sec && wdata <= rtc_pkg::SEC_MAX)
            begin
                sec_q <= wdata;
            end
            else if (tick1)
            begin
                sec_q <= sec_wrap ? 8'h00 : sec_q + 8'h01;
            end
            if (wr_min && wdata <= rtc_pkg::SEC_MAX)
            begin
                min_q <= wdata;
            end
            else if (sec_wrap)
            begin
                min_q <= min_wrap ? 8'h00 : min_q + 8'h01;
            end
            if (wr_hr && wdata <= rtc_pkg::HR_MAX)
            begin
                hr_q <= wdata;
            end
            else if (min_wrap)
            begin
                hr_q <= hr_wrap ? 8'h00 : hr_q + 8'h01;
            end
        end
    end

    // calendar counters
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            day_q <= rtc_pkg::DAY_RST;
            mth_q <= rtc_pkg::MTH_RST;
            yr_q <= rtc_pkg::ZERO_RST;
            dow_q <= rtc_pkg::ZERO_RST;
        end
        else if (clk_en)
        begin
            if (wr_day && wdata != 8'h00 && wdata <= dim)
            begin
                day_q <= wdata;
            end
            else if (hr_wrap)
            begin
                day_q <= day_wrap ? 8'h01 : day_q + 8'h01;
            end
            if (wr_mth && wdata != 8'h00 && wdata <= rtc_pkg::MTH_MAX)
            begin
                mth_q <= wdata;
            end
            else if (day_wrap)
            begin
                mth_q <= mth_wrap ? 8'h01 : mth_q + 8'h01;
            end
            if (wr_yr && wdata >= rtc_pkg::YR_MIN && wdata <= rtc_pkg::YR_MAX)
            begin
                yr_q <= wdata;
            end
            else if (mth_wrap)
            begin
                yr_q <= (yr_q >= rtc_pkg::YR_MAX) ? rtc_pkg::YR_MIN : yr_q + 8'h01;
            end
            if (wr_dow && wdata <= rtc_pkg::DOW_MAX)
            begin
                dow_q <= wdata;
            end
            else if (hr_wrap)
            begin
                dow_q <= (dow_q >= rtc_pkg::DOW_MAX) ? 8'h00 : dow_q + 8'h01;
            end
        end
    end

    // read port and request output
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_q <= |(flags_q & irq_en_q);
            if (rd_en)
            begin
                case (addr)
                    rtc_pkg::OFS_IRQ_EN: rdata_q <= irq_en_q;
                    rtc_pkg::OFS_CTRL2: rdata_q <= {1'b0, chrono_en_q, module_en_q, 2'b00,
                                                    xtal_q};
                    rtc_pkg::OFS_STATUS: rdata_q <= flags_q;
                    rtc_pkg::OFS_ALM_MIN: rdata_q <= alm_min_q;
                    rtc_pkg::OFS_ALM_HR: rdata_q <= alm_hr_q;
                    rtc_pkg::OFS_SEC: rdata_q <= sec_q;
                    rtc_pkg::OFS_MIN: rdata_q <= min_q;
                    rtc_pkg::OFS_HR: rdata_q <= hr_q;
                    rtc_pkg::OFS_DAY: rdata_q <= day_q;
                    rtc_pkg::OFS_MTH: rdata_q <= mth_q;
                    rtc_pkg::OFS_YR: rdata_q <= yr_q;
                    rtc_pkg::OFS_DOW: rdata_q <= dow_q;
                    rtc_pkg::OFS_CHR: rdata_q <= {1'b0, chr_val};
                    default: rdata_q <= 8'h00;
                endcase
            end
            else
            begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign rdata = rdata_q;
    assign irq_req = irq_q;

endmodule : calendar_clock_alarm_chrono

// File: hw/rtc_pkg.sv
// shared constants and types for the calendar clock block
package rtc_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_IRQ_EN = 8'h42;
    localparam logic [7:0] OFS_CTRL2 = 8'h43;
    localparam logic [7:0] OFS_STATUS = 8'h44;
    localparam logic [7:0] OFS_ALM_MIN = 8'h45;
    localparam logic [7:0] OFS_ALM_HR = 8'h46;
    localparam logic [7:0] OFS_SEC = 8'h47;
    localparam logic [7:0] OFS_MIN = 8'h48;
    localparam logic [7:0] OFS_HR = 8'h49;
    localparam logic [7:0] OFS_DAY = 8'h4A;
    localparam logic [7:0] OFS_MTH = 8'h4B;
    localparam logic [7:0] OFS_YR = 8'h4C;
    localparam logic [7:0] OFS_DOW = 8'h4D;
    localparam logic [7:0] OFS_CHR = 8'h4E;

    // second control register layout
    localparam int CTL_CHR_CLR = 7;
    localparam int CTL_CHR_EN = 6;
    localparam int CTL_MOD_EN = 5;
    localparam int CTL_XTAL_MSB = 2;

    // reset values
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [2:0] XTAL_RST = 3'h0;
    localparam logic [7:0] DAY_RST = 8'h01;
    localparam logic [7:0] MTH_RST = 8'h01;
    localparam logic [7:0] ZERO_RST = 8'h00;

    // crystal select encodings
    localparam logic [2:0] XTAL_32K768 = 3'h0;
    localparam logic [2:0] XTAL_RSVD = 3'h1;
    localparam logic [2:0] XTAL_32K000 = 3'h2;
    localparam logic [2:0] XTAL_38K400 = 3'h3;

    // reference frequencies in Hz and derived tick rates
    localparam int REF_HZ_32K768 = 32768;
    localparam int REF_HZ_32K000 = 32000;
    localparam int REF_HZ_38K400 = 38400;
    localparam int REF_HZ_64K000 = 64000;
    localparam int REF_HZ_76K800 = 76800;
    localparam int TB_RATE_HZ = 4;
    localparam int CHRONO_RATE_HZ = 100;
    localparam int CHRONO_RATE_32K_HZ = 128;

    // counter limits
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] HR_MAX = 8'h17;
    localparam logic [7:0] MTH_MAX = 8'h0C;
    localparam logic [7:0] DOW_MAX = 8'h06;
    localparam logic [7:0] YR_MAX = 8'hC7;
    localparam logic [7:0] YR_MIN = 8'h01;
    localparam logic [6:0] CHR_MAX = 7'h63;
    localparam logic [6:0] CHR_SUB_MAX_32K = 7'h7F;
    localparam logic [7:0] DAYS_28 = 8'h1C;
    localparam logic [7:0] DAYS_29 = 8'h1D;
    localparam logic [7:0] DAYS_30 = 8'h1E;
    localparam logic [7:0] DAYS_31 = 8'h1F;

    typedef struct packed {
        logic alarm;
        logic chrono;
        logic day;
        logic hour;
        logic minute;
        logic second;
        logic half;
        logic quarter;
    } flags_t;

endpackage : rtc_pkg

// File: tb/rtc_port_checker_assertions.sv
// concurrent checks on the register port of the calendar clock block
`timescale 1ns/100ps
module rtc_port_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic irq_req
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd(logic [7:0] a);
        clk_en && rd_en && addr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        clk_en && wr_en && addr == a;
    endsequence

    a_rdata_idle: assert property (clk_en && !rd_en |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    // the bench reads back two cycles after a write, with an idle cycle between
    a_enable_readback: assert property (s_wr(rtc_pkg::OFS_IRQ_EN)
        ##1 (clk_en && !wr_en) ##1 s_rd(rtc_pkg::OFS_IRQ_EN)
        |=> rdata == $past(wdata, 3))
        else $error("interrupt enable readback differs");
    a_unmapped_zero: assert property (clk_en && rd_en && (addr < 8'h42 || addr > 8'h4E)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_spare_zero: assert property (s_rd(rtc_pkg::OFS_CTRL2)
        |=> rdata[7] == 1'b0 && rdata[4:3] == 2'b00)
        else $error("control clear or spare bits read one");
    a_clock_range: assert property (clk_en && rd_en && (addr == 8'h47 || addr == 8'h48)
        |=> rdata <= rtc_pkg::SEC_MAX)
        else $error("second or minute out of range");
    a_hour_range: assert property (s_rd(rtc_pkg::OFS_HR) |=> rdata <= rtc_pkg::HR_MAX)
        else $error("hour out of range");
    a_day_range: assert property (s_rd(rtc_pkg::OFS_DAY)
        |=> rdata >= 8'h01 && rdata <= rtc_pkg::DAYS_31)
        else $error("day out of range");
    a_month_range: assert property (s_rd(rtc_pkg::OFS_MTH)
        |=> rdata >= 8'h01 && rdata <= rtc_pkg::MTH_MAX)
        else $error("month out of range");
    a_chrono_range: assert property (s_rd(rtc_pkg::OFS_CHR) |=> rdata <= 8'h63)
        else $error("stopwatch above 99");
    a_irq_masked: assert property (clk_en && wr_en && addr == 8'h42 && wdata == 8'h00
        |-> ##2 !irq_req [*2])
        else $error("request with all enables clear");
endmodule : rtc_port_checker

bind calendar_clock_alarm_chrono rtc_port_checker u_rtc_port_checker (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .irq_req(irq_req)
);

// File: tb/tb_calendar_clock_alarm_chrono.sv
// self-checking bench for the calendar clock block
`timescale 1ns/100ps
module tb_calendar_clock_alarm_chrono;
    logic clk_sys, rst_n, clk_en, stop_mode, osc_run_in_stop, wr_en, rd_en, irq_req;
    logic [1:0] ref_cnt;
    logic [7:0] addr, wdata, rdata, got, old;
    int bad_count, checks, cyc;

    // quarter divide of 4 reference edges keeps a second at 64 clocks
    calendar_clock_alarm_chrono #(
        .QDIV_32K768(4),
        .QDIV_32K000(4),
        .QDIV_38K400(4),
        .QDIV_64K000(4),
        .QDIV_76K800(4)
    ) u_calendar_clock_alarm_chrono (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .crystal_ref_clock(ref_cnt[1]),
        .stop_mode(stop_mode),
        .osc_run_in_stop(osc_run_in_stop),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .irq_req(irq_req)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        ref_cnt <= ref_cnt + 2'd1;
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            $display("[ERR] %0t run hung", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk8(d, e);
    endtask : chk_rd

    // load 23:59:59 on a date, run to midnight, then freeze and check
    task automatic roll(input logic [7:0] y, m, d, ed, em, ey);
        int n;
        wr(8'h4C, y);
        wr(8'h4B, m);
        wr(8'h4A, d);
        wr(8'h49, 8'h17);
        wr(8'h48, 8'h3B);
        wr(8'h47, 8'h3B);
        wr(8'h43, 8'h20);
        n = 0;
        got = 8'h3B;
        while (got !== 8'h00 && n < 40)
        begin
            rd(8'h47, got);
            n++;
        end
        wr(8'h43, 8'h00);
        chk_rd(8'h4A, ed);
        chk_rd(8'h4B, em);
        chk_rd(8'h4C, ey);
        chk_rd(8'h49, 8'h00);
        chk_rd(8'h48, 8'h00);
    endtask : roll

    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        ref_cnt = 2'd0;
        stop_mode = 1'b0;
        osc_run_in_stop = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_rd(8'h42, 8'h00);
        chk_rd(8'h4A, 8'h01);
        chk_rd(8'h4B, 8'h01);
        chk_rd(8'h50, 8'h00);
        wr(8'h42, 8'hA5);
        chk_rd(8'h42, 8'hA5);
        wr(8'h42, 8'h00);
        $display("reset and enable test done");
        roll(8'h01, 8'h0C, 8'h1F, 8'h01, 8'h01, 8'h02);
        roll(8'h01, 8'h04, 8'h1E, 8'h01, 8'h05, 8'h01);
        roll(8'h05, 8'h02, 8'h1C, 8'h01, 8'h03, 8'h05);
        roll(8'h04, 8'h02, 8'h1D, 8'h01, 8'h03, 8'h04);
        chk_rd(8'h4D, 8'h04);
        chk_rd(8'h44, 8'hBF);
        $display("calendar rollover test done");
        wr(8'h42, 8'h80);
        repeat (3) @(posedge clk_sys);
        chk8({7'h00, irq_req}, 8'h01);
        rd(8'h44, got);
        rd(8'h46, got);
        chk_rd(8'h44, 8'h3F);
        repeat (3) @(posedge clk_sys);
        chk8({7'h00, irq_req}, 8'h00);
        wr(8'h42, 8'h20);
        repeat (3) @(posedge clk_sys);
        chk8({7'h00, irq_req}, 8'h01);
        wr(8'h42, 8'h00);
        $display("flag and request test done");
        wr(8'h47, 8'h3C);
        chk_rd(8'h47, 8'h00);
        wr(8'h49, 8'h18);
        chk_rd(8'h49, 8'h00);
        wr(8'h4B, 8'h02);
        wr(8'h4A, 8'h1E);
        chk_rd(8'h4A, 8'h01);
        wr(8'h4A, 8'h1D);
        chk_rd(8'h4A, 8'h1D);
        wr(8'h4B, 8'h0D);
        chk_rd(8'h4B, 8'h02);
        $display("write range test done");
        wr(8'h43, 8'hE3);
        chk_rd(8'h43, 8'h60);
        repeat (2600) @(posedge clk_sys);
        wr(8'h43, 8'h20);
        rd(8'h4E, old);
        // two 128 Hz sub ticks in about 650 reference edges read as one hundredth
        chk8(old, 8'h01);
        rd(8'h44, got);
        chk8({7'h00, got[6]}, 8'h01);
        repeat (1200) @(posedge clk_sys);
        chk_rd(8'h4E, old);
        wr(8'h43, 8'hA0);
        chk_rd(8'h4E, 8'h00);
        chk_rd(8'h43, 8'h20);
        $display("stopwatch test done");
        @(posedge clk_sys) stop_mode <= 1'b1;
        rd(8'h47, old);
        repeat (200) @(posedge clk_sys);
        chk_rd(8'h47, old);
        @(posedge clk_sys) osc_run_in_stop <= 1'b1;
        repeat (200) @(posedge clk_sys);
        rd(8'h47, got);
        chk8({7'h00, got != old}, 8'h01);
        @(posedge clk_sys) stop_mode <= 1'b0;
        wr(8'h43, 8'h00);
        rd(8'h47, old);
        repeat (200) @(posedge clk_sys);
        chk_rd(8'h47, old);
        // a write while the clock enable is low must leave no trace
        @(posedge clk_sys) clk_en <= 1'b0;
        wr(8'h42, 8'hFF);
        @(posedge clk_sys) clk_en <= 1'b1;
        chk_rd(8'h42, 8'h00);
        chk8({7'h00, irq_req}, 8'h00);
        $display("low power test done");
        close_out();
    end
endmodule : tb_calendar_clock_alarm_chrono
